// >>> hdl/twc_pkg.sv
// Constants, register map and state types for the two-wire controller
package twc_pkg;
  localparam int unsigned PCLK_HZ = 100_000_000;
  localparam int unsigned STD_HZ = 100_000;
  localparam int unsigned FAST_HZ = 400_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BACKOFF_NS = 10_000;
  localparam logic [9:0] BACKOFF_CYC = 10'((BACKOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned DIV_SUM = PCLK_HZ / (2 * STD_HZ) - 2;
  localparam logic [7:0] DIVH_RST = 8'(DIV_SUM / 2);
  localparam logic [7:0] DIVL_RST = 8'(DIV_SUM - DIV_SUM / 2);
  localparam logic [9:0] DIV_BASE = 10'h002;
  localparam logic [9:0] SYNC_LAG = 10'h002;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Configuration bit positions and the status flush bit
  localparam int unsigned CFG_SCLEN = 7;
  localparam int unsigned CFG_LOOP = 6;
  localparam int unsigned CFG_NOBOFF = 5;
  localparam int unsigned CFG_HWGC = 4;
  localparam int unsigned CFG_GC = 3;
  localparam int unsigned CFG_MEN = 1;
  localparam int unsigned CFG_SEN = 0;
  localparam int unsigned STA_FLUSH = 7;
  // Register byte addresses
  localparam logic [11:0] A_CFG = 12'h000;
  localparam logic [11:0] A_DIVH = 12'h004;
  localparam logic [11:0] A_DIVL = 12'h008;
  localparam logic [11:0] A_SRX = 12'h00c;
  localparam logic [11:0] A_STX = 12'h010;
  localparam logic [11:0] A_SSTA = 12'h014;
  localparam logic [11:0] A_ID0 = 12'h018;
  localparam logic [11:0] A_ID1 = 12'h01c;
  localparam logic [11:0] A_ID2 = 12'h020;
  localparam logic [11:0] A_ID3 = 12'h024;
  localparam logic [11:0] A_MRX = 12'h028;
  localparam logic [11:0] A_MTX = 12'h02c;
  localparam logic [11:0] A_MSTA = 12'h030;
  localparam logic [11:0] A_CNT = 12'h034;
  localparam logic [11:0] A_ADR = 12'h038;
  localparam logic [11:0] A_ALT = 12'h03c;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_START = 3'h1, M_LOW = 3'h3, M_HIGH = 3'h2,
    M_STOP = 3'h6, M_STOP2 = 3'h7, M_WAIT = 3'h4
  } twc_mst_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h3, S_RX = 3'h2,
    S_RACK = 3'h6, S_TX = 3'h7, S_TACK = 3'h5
  } twc_sst_t;

  typedef struct packed {
    logic [7:0] cfg, divh, divl, cnt, adr, alt;
    logic [3:0][7:0] own;
    logic [7:0] mtx, mrx, stx, srx;
    logic mtx_v, mrx_f, stx_v, srx_f, mflush, sflush;
    logic m_arb, m_nack, m_ovf, m_rxirq, m_txirq;
    logic s_nack, s_ovf, s_rxirq, s_txirq, s_unf;
    logic scl_s1, scl_s2, sda_s1, sda_s2, scl_p, sda_p, bus_busy;
    twc_mst_t mst;
    logic [9:0] div, boff;
    logic [3:0] m_bit;
    logic [7:0] m_sh, left;
    logic m_rd, m_adrph, m_req, m_scl, m_sda, men_p;
    twc_sst_t sst;
    logic [3:0] s_bit;
    logic [7:0] s_sh;
    logic s_rd, s_sda;
    logic [31:0] prdata;
    logic pready, pslverr, scl_oe, sda_oe, line_lo;
  } twc_state_t;
endpackage

// >>> hdl/twc_ctrl.sv
// Two-wire bus controller with concurrent master and slave channels and APB registers
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Clock and data pins only pull low; released lines float high.
// - Four own-address registers; a match on any makes the slave respond.
// - START on idle bus, address with direction, data if acked, STOP.
// - Master and slave channels run independently and concurrently.
// - Slave wakes on each START; unaddressed it sleeps until next START.
// - A master that loses arbitration can still be addressed as slave.
// - Master makes the bus clock; standard and fast rates supported.
// - Bus clock equals core clock over twice (2 + high + low divider).
// - Upper seven address bits compared against each own address.
// - Own address bit 0 is ignored in the comparison.
// - Sixteen 8-bit registers program the controller.
// - Read count sets how many bytes a master read takes.
// - Without pending transmit data the target address is sent first.
// - Slave has a separate general call identifier register.
// - Config bit 7 starts or stops master clock generation.
// - Config bit 6 loops transmitted levels back to the receive path.
// - Config bit 5 retries at once after lost arbitration, else backs off.
// - Config bit 4 enables the identifier general call, needs bit 3.
// - Config bit 3 makes the device answer the general call address.
// - Config bit 1 enables the master channel.
// - Config bit 0 enables the slave channel and its address monitor.
module twc_ctrl
  import twc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  twc_state_t q;
  twc_state_t n;
  logic scl_ln, sda_ln, start_c, stop_c, scl_rise, scl_fall;
  logic [9:0] hp, mid;
  logic run, tick, tx_mode, ack_drv, setup, acc, hit, mapped;
  logic [3:0] own_hit;
  logic [7:0] rd_val;

  function automatic logic addr_match(input logic [7:0] a, input logic [7:0] id);
    return a[7:1] == id[7:1];
  endfunction

  // Bits 7..1 of the received byte against each own address
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_own
      assign own_hit[g] = addr_match(q.s_sh, q.own[g]);
    end
  endgenerate

  assign hit = (|own_hit) || (q.cfg[CFG_GC] && q.s_sh == GCALL_ADDR)
    || (q.cfg[CFG_GC] && q.cfg[CFG_HWGC] && addr_match(q.s_sh, q.alt));

  // Loopback sees only our own drive, so software can test without a bus
  assign scl_ln = q.cfg[CFG_LOOP] ? ~q.scl_oe : q.scl_s2;
  assign sda_ln = q.cfg[CFG_LOOP] ? ~q.sda_oe : q.sda_s2;
  assign start_c = q.scl_p && scl_ln && q.sda_p && !sda_ln;
  assign stop_c = q.scl_p && scl_ln && !q.sda_p && sda_ln;
  assign scl_rise = scl_ln && !q.scl_p;
  assign scl_fall = !scl_ln && q.scl_p;

  assign hp = DIV_BASE + {2'b00, q.divh} + {2'b00, q.divl};
  assign mid = hp >> 1;
  // High phases wait for the line so a stretching slave slows us down;
  // the first counts run blind to cover the input synchroniser delay
  assign run = q.cfg[CFG_SCLEN] && !((q.mst == M_HIGH || q.mst == M_STOP2) && !scl_ln
    && q.div >= SYNC_LAG);
  assign tick = run && q.div == hp - 10'h001;
  assign tx_mode = q.m_adrph || !q.m_rd;
  assign ack_drv = (q.left > 8'h01) && !q.mrx_f;

  assign setup = psel && !penable;
  assign acc = psel && penable && q.pready;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      A_CFG: rd_val = q.cfg;
      A_DIVH: rd_val = q.divh;
      A_DIVL: rd_val = q.divl;
      A_SRX: rd_val = q.srx;
      A_STX: rd_val = BYTE_RST;
      A_SSTA: rd_val = {q.sflush, q.sst != S_IDLE, q.s_nack, q.s_ovf, q.s_rxirq,
                        q.s_txirq, q.s_unf, !q.stx_v};
      A_ID0: rd_val = q.own[0];
      A_ID1: rd_val = q.own[1];
      A_ID2: rd_val = q.own[2];
      A_ID3: rd_val = q.own[3];
      A_MRX: rd_val = q.mrx;
      A_MTX: rd_val = BYTE_RST;
      A_MSTA: rd_val = {q.mflush, q.mst != M_IDLE, q.m_arb, q.m_nack, q.m_ovf,
                        q.m_rxirq, q.m_txirq, !q.mtx_v};
      A_CNT: rd_val = q.cnt;
      A_ADR: rd_val = q.adr;
      A_ALT: rd_val = q.alt;
      default: begin
        rd_val = BYTE_RST;
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    n = q;
    n.scl_s1 = scl_i;
    n.scl_s2 = q.scl_s1;
    n.sda_s1 = sda_i;
    n.sda_s2 = q.sda_s1;
    n.scl_p = scl_ln;
    n.sda_p = sda_ln;
    if (start_c) begin
      n.bus_busy = 1'b1;
    end else if (stop_c) begin
      n.bus_busy = 1'b0;
    end
    // Bus handshake: answer is ready in the first access cycle
    n.pready = setup;
    n.pslverr = setup && !mapped;
    if (setup) begin
      n.prdata = {24'h000000, rd_val};
    end
    // Flag clears come before the channels so a same-cycle event wins
    if (acc && !pwrite && paddr == A_MRX) begin
      n.m_ovf = 1'b0;
      n.m_rxirq = 1'b0;
      n.mrx_f = 1'b0;
    end
    if (acc && !pwrite && paddr == A_SRX) begin
      n.s_ovf = 1'b0;
      n.s_rxirq = 1'b0;
      n.srx_f = 1'b0;
    end
    if (acc && pwrite && paddr == A_MTX) begin
      n.m_txirq = 1'b0;
    end
    if (acc && pwrite && paddr == A_STX) begin
      n.s_txirq = 1'b0;
      n.s_unf = 1'b0;
      n.s_nack = 1'b0;
    end

    // Master channel
    n.men_p = q.cfg[CFG_MEN];
    if (q.cfg[CFG_MEN] && !q.men_p) begin
      n.m_req = 1'b1;
    end
    if (q.mst == M_IDLE || q.mst == M_WAIT || tick) begin
      n.div = 10'h000;
    end else if (run) begin
      n.div = q.div + 10'h001;
    end
    if (!q.cfg[CFG_MEN]) begin
      n.mst = M_IDLE;
      n.m_scl = 1'b0;
      n.m_sda = 1'b0;
      n.m_req = 1'b0;
    end else begin
      case (q.mst)
        M_IDLE: begin
          if (q.m_req && !q.bus_busy) begin
            n.mst = M_START;
            n.m_sda = 1'b1;
            n.m_sh = q.mtx_v ? q.mtx : q.adr;
            n.m_rd = q.mtx_v ? q.mtx[0] : q.adr[0];
            n.mtx_v = 1'b0;
            n.m_adrph = 1'b1;
            n.m_bit = 4'h0;
          end
        end
        M_START: begin
          if (tick) begin
            n.m_scl = 1'b1;
            n.mst = M_LOW;
          end
        end
        M_LOW: begin
          // Data changes mid-way through the low phase, clear of both edges
          if (q.div == mid) begin
            if (q.m_bit < BIT_ACK) begin
              n.m_sda = tx_mode && !q.m_sh[7];
            end else begin
              n.m_sda = !tx_mode && ack_drv;
            end
          end
          if (tick) begin
            n.m_scl = 1'b0;
            n.mst = M_HIGH;
          end
        end
        M_HIGH: begin
          if (tick && q.m_bit < BIT_ACK) begin
            if (tx_mode && !q.m_sda && !sda_ln) begin
              n.m_arb = 1'b1;
              n.m_sda = 1'b0;
              n.mst = M_WAIT;
              n.boff = 10'h000;
            end else begin
              n.m_sh = {q.m_sh[6:0], sda_ln};
              n.m_bit = q.m_bit + 4'h1;
              n.m_scl = 1'b1;
              n.mst = M_LOW;
            end
          end else if (tick) begin
            n.m_bit = 4'h0;
            n.m_scl = 1'b1;
            n.mst = M_LOW;
            n.m_adrph = 1'b0;
            if (tx_mode) begin
              if (sda_ln) begin
                n.m_nack = 1'b1;
                n.mst = M_STOP;
              end else if (q.m_adrph && q.m_rd) begin
                n.left = q.cnt;
                if (q.cnt == BYTE_RST) begin
                  n.mst = M_STOP;
                end
              end else begin
                n.m_txirq = 1'b1;
                if (q.mtx_v) begin
                  n.m_sh = q.mtx;
                  n.mtx_v = 1'b0;
                end else begin
                  n.mst = M_STOP;
                end
              end
            end else begin
              n.mrx = q.m_sh;
              n.m_rxirq = 1'b1;
              n.m_ovf = q.m_ovf || q.mrx_f;
              n.mrx_f = 1'b1;
              n.left = q.left - 8'h01;
              if (!q.m_sda && q.left > 8'h01) begin
                n.m_nack = 1'b1;
              end
              if (q.left <= 8'h01 || !q.m_sda) begin
                n.mst = M_STOP;
              end
            end
          end
        end
        M_STOP: begin
          if (q.div == mid) begin
            n.m_sda = 1'b1;
          end
          if (tick) begin
            n.m_scl = 1'b0;
            n.mst = M_STOP2;
          end
        end
        M_STOP2: begin
          if (tick) begin
            n.m_sda = 1'b0;
            n.mst = M_IDLE;
            n.m_req = 1'b0;
          end
        end
        M_WAIT: begin
          // Request stays pending so the master tries again on a free bus
          if (q.bus_busy) begin
            n.boff = 10'h000;
          end else if (q.cfg[CFG_NOBOFF] || q.boff == BACKOFF_CYC - 10'h001) begin
            n.mst = M_IDLE;
            n.m_arb = 1'b0;
          end else begin
            n.boff = q.boff + 10'h001;
          end
        end
        default: begin
          n.mst = M_IDLE;
          n.m_scl = 1'b0;
          n.m_sda = 1'b0;
        end
      endcase
    end

    // Slave channel, unaffected by the master's state
    if (!q.cfg[CFG_SEN]) begin
      n.sst = S_IDLE;
      n.s_sda = 1'b0;
    end else if (start_c) begin
      n.sst = S_ADDR;
      n.s_bit = 4'h0;
      n.s_sda = 1'b0;
    end else if (stop_c) begin
      n.sst = S_IDLE;
      n.s_sda = 1'b0;
    end else begin
      case (q.sst)
        S_IDLE: n.s_sda = 1'b0;
        S_ADDR, S_RX: begin
          if (scl_rise && q.s_bit < BIT_ACK) begin
            n.s_sh = {q.s_sh[6:0], sda_ln};
            n.s_bit = q.s_bit + 4'h1;
          end else if (scl_fall && q.s_bit == BIT_ACK) begin
            n.s_sda = 1'b1;
            if (q.sst == S_RX) begin
              n.srx = q.s_sh;
              n.s_rxirq = 1'b1;
              n.s_ovf = q.s_ovf || q.srx_f;
              n.srx_f = 1'b1;
              n.sst = S_RACK;
            end else if (hit) begin
              n.s_rd = q.s_sh[0];
              n.sst = S_AACK;
            end else begin
              n.s_sda = 1'b0;
              n.sst = S_IDLE;
            end
          end
        end
        S_AACK, S_TACK: begin
          if (q.sst == S_TACK && scl_rise && sda_ln) begin
            n.sst = S_IDLE;
          end else if (scl_fall) begin
            n.s_bit = 4'h0;
            if (q.sst == S_AACK && !q.s_rd) begin
              n.s_sda = 1'b0;
              n.sst = S_RX;
            end else begin
              // Empty transmit holder repeats the stale byte and flags it
              n.s_sh = q.stx;
              n.s_sda = !q.stx[7];
              n.stx_v = 1'b0;
              n.s_unf = q.s_unf || !q.stx_v;
              n.s_nack = q.s_nack || !q.stx_v;
              n.sst = S_TX;
            end
          end
        end
        S_RACK: begin
          if (scl_fall) begin
            n.s_sda = 1'b0;
            n.s_bit = 4'h0;
            n.sst = S_RX;
          end
        end
        S_TX: begin
          if (scl_rise) begin
            n.s_bit = q.s_bit + 4'h1;
          end else if (scl_fall && q.s_bit == BIT_ACK) begin
            n.s_sda = 1'b0;
            n.s_txirq = 1'b1;
            n.sst = S_TACK;
          end else if (scl_fall) begin
            n.s_sh = {q.s_sh[6:0], 1'b0};
            n.s_sda = !q.s_sh[6];
          end
        end
        default: begin
          n.sst = S_IDLE;
          n.s_sda = 1'b0;
        end
      endcase
    end

    // Register writes last so new transmit data survives a same-cycle load
    if (acc && pwrite) begin
      case (paddr)
        A_CFG: n.cfg = pwdata[7:0];
        A_DIVH: n.divh = pwdata[7:0];
        A_DIVL: n.divl = pwdata[7:0];
        A_STX: begin
          n.stx = pwdata[7:0];
          n.stx_v = 1'b1;
        end
        A_SSTA: n.sflush = pwdata[STA_FLUSH];
        A_ID0: n.own[0] = pwdata[7:0];
        A_ID1: n.own[1] = pwdata[7:0];
        A_ID2: n.own[2] = pwdata[7:0];
        A_ID3: n.own[3] = pwdata[7:0];
        A_MTX: begin
          n.mtx = pwdata[7:0];
          n.mtx_v = 1'b1;
        end
        A_MSTA: n.mflush = pwdata[STA_FLUSH];
        A_CNT: n.cnt = pwdata[7:0];
        A_ADR: n.adr = pwdata[7:0];
        A_ALT: n.alt = pwdata[7:0];
        default: n.cfg = q.cfg;
      endcase
    end
    if (n.mflush) begin
      n.mtx_v = 1'b0;
    end
    if (n.sflush) begin
      n.stx_v = 1'b0;
    end
    n.scl_oe = n.m_scl;
    n.sda_oe = n.m_sda || n.s_sda;
    n.line_lo = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.divh <= DIVH_RST;
      q.divl <= DIVL_RST;
      q.mst <= M_IDLE;
      q.sst <= S_IDLE;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign scl_o = q.line_lo;
  assign sda_o = q.line_lo;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;

  // Checks
  logic [9:0] lo_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt <= 10'h000;
    end else if (q.mst == M_LOW && q.cfg[CFG_SCLEN]) begin
      lo_cnt <= lo_cnt + 10'h001;
    end else begin
      lo_cnt <= 10'h000;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  addr_match_a: assert property ((q.cfg[CFG_SEN] && q.sst == S_ADDR && scl_fall && !start_c
    && !stop_c && q.s_bit == BIT_ACK && |own_hit) |=> (q.sst == S_AACK && q.s_sda))
    else $error("own address not acknowledged");
  no_match_a: assert property ((q.cfg[CFG_SEN] && q.sst == S_ADDR && scl_fall && !start_c
    && !stop_c && q.s_bit == BIT_ACK && !hit) |=> (q.sst == S_IDLE && !q.s_sda))
    else $error("slave stayed awake unaddressed");
  gen_call_a: assert property ((q.cfg[CFG_SEN] && q.cfg[CFG_GC] && q.sst == S_ADDR
    && scl_fall && !start_c && !stop_c && q.s_bit == BIT_ACK && q.s_sh == GCALL_ADDR)
    |=> q.sst == S_AACK)
    else $error("general call ignored");
  clk_gate_a: assert property ((!q.cfg[CFG_SCLEN] && q.mst == M_LOW) |=> $stable(q.div))
    else $error("divider ran while clock disabled");
  low_len_a: assert property ((q.mst == M_LOW && tick && q.cfg[CFG_MEN])
    |-> (lo_cnt == hp - 10'h001) ##1 q.mst == M_HIGH)
    else $error("low phase length wrong");
  master_off_a: assert property (!q.cfg[CFG_MEN] |=> (q.mst == M_IDLE && !q.m_scl && !q.m_sda))
    else $error("master active while disabled");
  slave_off_a: assert property (!q.cfg[CFG_SEN] |=> (q.sst == S_IDLE && !q.s_sda))
    else $error("slave active while disabled");
  auto_addr_a: assert property ((q.cfg[CFG_MEN] && q.mst == M_IDLE && q.m_req && !q.bus_busy
    && !q.mtx_v) |=> (q.mst == M_START && q.m_sh == $past(q.adr) && q.m_adrph))
    else $error("target address not loaded");
  retry_a: assert property ((q.cfg[CFG_MEN] && q.cfg[CFG_NOBOFF] && q.mst == M_WAIT
    && !q.bus_busy) |=> q.mst == M_IDLE)
    else $error("no immediate retry");
  read_cnt_a: assert property ((q.cfg[CFG_MEN] && q.mst == M_HIGH && tick && !tx_mode
    && q.m_bit == BIT_ACK && q.left == 8'h01) |=> (q.mst == M_STOP && q.left == 8'h00))
    else $error("read did not end at count");
endmodule
`default_nettype wire

// >>> dv/twc_peer.sv
// Behavioural two-wire slave with one address and clock hold at the start of each ack bit
`timescale 1ns/1ns
`default_nettype none
module twc_peer #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter int HOLD = 20
) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  output logic scl_pull,
  output logic [7:0] last_rx,
  output int nbytes
);
  logic scl_q = 1'b1, sda_q = 1'b1, act = 1'b0, rd = 1'b0, aph = 1'b0, pull = 1'b0;
  logic [3:0] bn = 4'h0;
  logic [7:0] sh = 8'h00, tx = 8'hc3, lrx = 8'h00;
  int hold = 0, nb = 0;
  // Pull-only outputs; the bench wires them as wired-AND
  assign sda_pull = pull;
  assign scl_pull = hold != 0;
  assign last_rx = lrx;
  assign nbytes = nb;
  always @(posedge pclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (hold != 0) hold <= hold - 1;
    if (scl && scl_q && sda_q != sda) begin
      act <= !sda;
      aph <= 1'b1;
      bn <= 4'h0;
      pull <= 1'b0;
      tx <= 8'hc3;
      if (!sda) nb <= 0;
    end else if (act && scl && !scl_q) begin
      sh <= {sh[6:0], sda};
      if (bn == 4'h8) begin
        bn <= 4'h0;
        aph <= 1'b0;
        // Master nack on a read byte ends our part
        if (rd && !aph) begin
          nb <= nb + 1;
          tx <= tx + 8'h01;
          if (sda) act <= 1'b0;
        end
      end else bn <= bn + 4'h1;
    end else if (act && !scl && scl_q) begin
      if (bn == 4'h8) begin
        hold <= HOLD;
        if (aph) begin
          pull <= sh[7:1] == ADDR;
          act <= sh[7:1] == ADDR;
          rd <= sh[0];
        end else if (!rd) begin
          pull <= 1'b1;
          lrx <= sh;
          nb <= nb + 1;
        end else pull <= 1'b0;
      end else pull <= rd && !aph && !tx[3'(7 - bn)];
    end
  end
endmodule
`default_nettype wire

// >>> dv/twc_ctrl_tb_top.sv
// Self-checking bench for the two-wire controller
`timescale 1ns/1ns
`default_nettype none
module twc_ctrl_tb_top;
  import twc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, p_sda, p_scl, e;
  logic [7:0] p_rx;
  int p_n, per, fails = 0, comparisons = 0;
  wire logic scl = !(scl_oe || p_scl);
  wire logic sda = !(sda_oe || p_sda);
  always #5 pclk = ~pclk;
  twc_ctrl twc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  twc_peer #(.ADDR(7'h2a), .HOLD(20)) twc_peer_i (.pclk(pclk), .scl(scl), .sda(sda),
    .sda_pull(p_sda), .scl_pull(p_scl), .last_rx(p_rx), .nbytes(p_n));

  task automatic test_done;
    $display("counts fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      $display("MISMATCH %s expected %h seen %h", n, x, s);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      fails++;
      test_done();
    end
  endtask
  task automatic rd_chk(input string n, input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    check(n, q, {24'h0, x});
  endtask
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 8'h00);
      n++;
    end while (q[b] !== v && n < 500);
    if (n == 500) begin
      fails++;
      test_done();
    end
  endtask
  // Cycles up to the next start of a low half driven by the master
  task automatic rise(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (scl_oe !== 1'b0 && n < 2000);
    do begin
      @(posedge pclk);
      n++;
    end while (scl_oe !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fails++;
      test_done();
    end
  endtask
  // Enable edge starts the address byte; data is queued behind it
  task automatic m_write(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    int n;
    apb(1'b1, A_CFG, c | 8'h01);
    apb(1'b1, A_ADR, a);
    apb(1'b1, A_CFG, c | 8'h83);
    rise(n);
    apb(1'b1, A_MTX, d);
    rise(n);
    rise(per);
    poll(A_MSTA, 6, 1'b0);
  endtask

  task automatic t_regs;
    logic [11:0] a [10] = '{A_CFG, A_DIVH, A_DIVL, A_ID0, A_ID3, A_CNT, A_ADR, A_ALT,
      A_MTX, A_STX};
    logic [7:0] x [10] = '{8'h00, 8'hf9, 8'hf9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    for (int i = 0; i < 10; i++) rd_chk("reset value", a[i], x[i]);
    apb(1'b0, 12'h040, 8'h00);
    check("pslverr unmapped", e, 1);
    apb(1'b1, A_MRX, 8'h77);
    rd_chk("read-only rx", A_MRX, 8'h00);
    apb(1'b1, A_ALT, 8'h4c);
    rd_chk("identifier", A_ALT, 8'h4c);
    apb(1'b1, A_DIVH, 8'h03);
    apb(1'b1, A_DIVL, 8'h03);
    rd_chk("divider", A_DIVH, 8'h03);
  endtask
  task automatic t_own;
    apb(1'b1, A_ID2, 8'ha3);
    m_write(8'ha2, 8'h5a, 8'h00);
    apb(1'b0, A_MSTA, 8'h00);
    check("own slave ack", q[4], 0);
    rd_chk("own slave rx", A_SRX, 8'h5a);
  endtask
  task automatic t_peer;
    m_write(8'h54, 8'h3c, 8'h00);
    check("bit period", per, 2 * (2 + 3 + 3));
    check("peer rx", p_rx, 8'h3c);
    check("peer count", p_n, 1);
    apb(1'b1, A_CNT, 8'h02);
    apb(1'b1, A_ADR, 8'h55);
    apb(1'b1, A_CFG, 8'h01);
    apb(1'b1, A_CFG, 8'h83);
    for (int i = 0; i < 2; i++) begin
      poll(A_MSTA, 2, 1'b1);
      rd_chk("master rx", A_MRX, 8'(8'hc3 + i));
    end
    poll(A_MSTA, 6, 1'b0);
    check("read count", p_n, 2);
  endtask
  // Own addresses moved off zero so only the call bits can match
  task automatic t_gcall;
    apb(1'b1, A_ID0, 8'h10);
    apb(1'b1, A_ID1, 8'h12);
    apb(1'b1, A_ID3, 8'h16);
    m_write(8'h00, 8'h99, 8'h08);
    apb(1'b0, A_MSTA, 8'h00);
    check("general call ack", q[4], 0);
    rd_chk("general call rx", A_SRX, 8'h99);
    m_write(8'h4c, 8'h98, 8'h18);
    rd_chk("identifier call rx", A_SRX, 8'h98);
  endtask
  // Own master reads one byte from own slave
  task automatic t_slave_tx;
    apb(1'b1, A_STX, 8'h96);
    apb(1'b1, A_CNT, 8'h01);
    apb(1'b1, A_ADR, 8'ha3);
    apb(1'b1, A_CFG, 8'h01);
    apb(1'b1, A_CFG, 8'h83);
    poll(A_MSTA, 2, 1'b1);
    rd_chk("own slave tx", A_MRX, 8'h96);
    poll(A_MSTA, 6, 1'b0);
    rd_chk("slave status", A_SSTA, 8'h05);
  endtask
  task automatic t_unmatched;
    m_write(8'h66, 8'h11, 8'h00);
    apb(1'b0, A_MSTA, 8'h00);
    check("address nack", q[4], 1);
    rd_chk("idle slave rx", A_SRX, 8'h98);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_own();
    t_peer();
    t_gcall();
    t_slave_tx();
    t_unmatched();
    check("scl low value", scl_o, 0);
    check("sda low value", sda_o, 0);
    test_done();
  end
endmodule
`default_nettype wire
